/* File: hw/clk_pwr_params.svh */
// Purpose: constants for the clock and power mode controller
// Assumes: 25 MHz system clock, byte addresses on the register port
// Notes:   times are given in their own unit, cycle counts derive from them
//
// Function
// - divided oscillator clocks have 50% duty
// - main oscillator offers 3/6/12/24/48/74 MHz
// - doubler doubles inputs of 6 to 24 MHz
// - doubler source: main, fast crystal, pin
// - pll output limited to 24..80 MHz
// - pll dividers give 4032 ratios
// - pll locks within 250 us, lock readable
// - pll reference: main, fast crystal, pin
// - pll lock routed out for interrupt
// - slow oscillator gives 1, 33, 100 kHz
// - tick wheel is free 13-bit 1 kHz counter
// - wheel halts in hibernate and debug stop
// - wheel makes periodic interrupts and wakeups
// - firmware command clears the wheel
// - four modes active, alternate, sleep, hibernate
// - per-mode template enables subsystems when active
// - sleep disables all except timed sleep, rtc
// - hibernate stops clocks, wakes on pins only
// - sleep wake sources within 25 us, resets
// - hibernate wakes by port events, 200 us
// - mode entry by wakeup, reset, register write
`ifndef CLK_PWR_PARAMS_SVH
`define CLK_PWR_PARAMS_SVH

`define CLK_PERIOD_NS     40
`define PLL_LOCK_US       250
`define SLEEP_WAKE_US     25
`define HIB_WAKE_US       200
`define HALF_1K_NS        500000
`define HALF_33K_NS       15151
`define HALF_100K_NS      5000

// register byte addresses
`define ADDR_OSC_CFG      8'h00
`define ADDR_DBL_CFG      8'h04
`define ADDR_PLL_CFG      8'h08
`define ADDR_STATUS       8'h0c
`define ADDR_WHEEL_CNT    8'h10
`define ADDR_WHEEL_CTL    8'h14
`define ADDR_MODE         8'h18
`define ADDR_TEMPLATE     8'h1c

// field positions
`define F_OSC_SEL         2:0
`define F_OSC_1K          3
`define F_OSC_33K         4
`define F_OSC_100K        5
`define F_OSC_DIV         15:8
`define F_EN              0
`define F_SRC             2:1
`define F_PLL_QM1         13:8
`define F_PLL_P           21:16
`define F_WH_CLR          0
`define F_WH_TAP          4:1
`define F_WH_IRQ          5
`define F_WH_WAKE         6
`define F_MODE            1:0
`define F_TPL_ACT         7:0
`define F_TPL_ALT         15:8

`define OSC_CFG_RST       32'h0000_0001
`define TPL_RST           16'hffff
`define DBL_MIN_MHZ       8'h06
`define DBL_MAX_MHZ       8'h18
`define PLL_MIN_MHZ       16'h0018
`define PLL_MAX_MHZ       16'h0050
`define WHEEL_W           13
`define WHEEL_MAX_TAP     4'hc

`endif

/* File: hw/clk_pwr_pkg.sv */
// Purpose: shared types of the clock and power mode controller
// Assumes: constants live in clk_pwr_params.svh
// Notes:   mode states are one-hot
package clk_pwr_pkg;

  typedef enum logic [4:0] {
    PM_ACTIVE = 5'h01,
    PM_ALT    = 5'h02,
    PM_SLEEP  = 5'h04,
    PM_HIB    = 5'h08,
    PM_WAKE   = 5'h10
  } pmode_t;

  typedef enum logic [1:0] {
    SRC_MAIN  = 2'h0,
    SRC_XTAL  = 2'h1,
    SRC_PIN   = 2'h2
  } clk_src_t;

  typedef struct packed {
    logic cmp;
    logic port_irq;
    logic i2c;
    logic rtc;
    logic lsd;
  } wake_src_t;

  typedef struct packed {
    logic external_reset_pin;
    logic low_supply_detect;
    logic watchdog_reset_event;
  } reset_src_t;

endpackage : clk_pwr_pkg

/* File: hw/clock_and_power_mode_control.sv */
// Purpose: oscillator control, doubler, pll supervision, tick wheel, power modes
// Assumes: oscillators are analog; this logic selects, supervises and divides
// Notes:   slow clocks are synthesised from clk for the timing logic
`include "clk_pwr_params.svh"
`timescale 1ns/10ps
module clock_and_power_mode_control
  import clk_pwr_pkg::*;
#(
  parameter int LOCK_CYCLES    = `PLL_LOCK_US * 1000 / `CLK_PERIOD_NS,
  parameter int HIB_WAKE_CYC   = `HIB_WAKE_US * 1000 / `CLK_PERIOD_NS,
  parameter int HALF_1K_CYC    = `HALF_1K_NS / `CLK_PERIOD_NS
)(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rdata,
  input  wire logic [7:0]  xtal_mhz,
  input  wire logic [7:0]  pin_clk_mhz,
  input  wire logic        debug_halt,
  input  wire wake_src_t   wake_src,
  input  wire reset_src_t  reset_src,
  output logic      [2:0]  main_osc_sel,
  output logic             main_osc_div_clk,
  output logic             one_khz_tick_clock,
  output logic             clk_33k,
  output logic             clk_100k,
  output logic      [7:0]  doubler_mhz,
  output logic             pll_enable,
  output logic             pll_lock,
  output logic      [12:0] wheel_count,
  output logic             wheel_irq,
  output pmode_t           power_mode,
  output logic      [7:0]  subsys_en,
  output logic             sleep_timer_run,
  output logic             clocks_run,
  output logic             dev_reset_req
);

  localparam int SLEEP_WAKE_CYC = `SLEEP_WAKE_US * 1000 / `CLK_PERIOD_NS;
  localparam int HALF_33K_CYC   = `HALF_33K_NS / `CLK_PERIOD_NS;
  localparam int HALF_100K_CYC  = `HALF_100K_NS / `CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [31:0] osc_cfg_q, osc_cfg_d, dbl_cfg_q, dbl_cfg_d, pll_cfg_q, pll_cfg_d;
  logic [31:0] wh_ctl_q, wh_ctl_d, rdata_q, rdata_d;
  logic [15:0] tpl_q, tpl_d;
  logic        mode_wr, wheel_clr;
  logic [1:0]  mode_code;
  logic [31:0] status;

  always_comb
  begin
    osc_cfg_d = osc_cfg_q;
    dbl_cfg_d = dbl_cfg_q;
    pll_cfg_d = pll_cfg_q;
    wh_ctl_d  = wh_ctl_q;
    tpl_d     = tpl_q;
    mode_wr   = 1'b0;
    wheel_clr = 1'b0;
    rdata_d   = 32'h0000_0000;
    if (wr_stb)
    begin
      case (addr)
        `ADDR_OSC_CFG:   osc_cfg_d = {16'h0000, wdata[15:0]};
        `ADDR_DBL_CFG:   dbl_cfg_d = {29'h0, wdata[2:0]};
        `ADDR_PLL_CFG:   pll_cfg_d = {10'h000, wdata[21:0]};
        `ADDR_WHEEL_CTL:
        begin
          wh_ctl_d  = {25'h0, wdata[6:1], 1'b0};
          wheel_clr = wdata[`F_WH_CLR];
        end
        `ADDR_MODE:      mode_wr = 1'b1;
        `ADDR_TEMPLATE:  tpl_d = wdata[15:0];
        default:         osc_cfg_d = osc_cfg_q;
      endcase
    end
    if (rd_stb)
    begin
      case (addr)
        `ADDR_OSC_CFG:   rdata_d = osc_cfg_q;
        `ADDR_DBL_CFG:   rdata_d = dbl_cfg_q;
        `ADDR_PLL_CFG:   rdata_d = pll_cfg_q;
        `ADDR_STATUS:    rdata_d = status;
        `ADDR_WHEEL_CNT: rdata_d = {19'h0, wheel_count};
        `ADDR_WHEEL_CTL: rdata_d = wh_ctl_q;
        `ADDR_MODE:      rdata_d = {30'h0, mode_code};
        `ADDR_TEMPLATE:  rdata_d = {16'h0000, tpl_q};
        default:         rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      osc_cfg_q <= `OSC_CFG_RST;
      dbl_cfg_q <= 32'h0000_0000;
      pll_cfg_q <= 32'h0000_0000;
      wh_ctl_q  <= 32'h0000_0000;
      tpl_q     <= `TPL_RST;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      osc_cfg_q <= osc_cfg_d;
      dbl_cfg_q <= dbl_cfg_d;
      pll_cfg_q <= pll_cfg_d;
      wh_ctl_q  <= wh_ctl_d;
      tpl_q     <= tpl_d;
      rdata_q   <= rdata_d;
    end
  end
  assign rdata = rdata_q;

  // ----------------------------------------------------------------
  // frequency bookkeeping: main oscillator, doubler, pll range
  // ----------------------------------------------------------------
  logic [7:0]  main_mhz, dbl_src_mhz, pll_ref_mhz;
  logic        dbl_ok, pll_range_ok;
  logic [15:0] pll_num, pll_lo, pll_hi;
  logic [6:0]  pll_q;
  logic [5:0]  pll_p;

  always_comb
  begin
    case (osc_cfg_q[`F_OSC_SEL])
      3'h0:    main_mhz = 8'h03;
      3'h1:    main_mhz = 8'h06;
      3'h2:    main_mhz = 8'h0c;
      3'h3:    main_mhz = 8'h18;
      3'h4:    main_mhz = 8'h30;
      3'h5:    main_mhz = 8'h4a;
      default: main_mhz = 8'h03;
    endcase
  end
  assign main_osc_sel = (osc_cfg_q[`F_OSC_SEL] > 3'h5) ? 3'h0 : osc_cfg_q[`F_OSC_SEL];

  function automatic logic [7:0] src_mhz(input logic [1:0] s, input logic [7:0] m,
                                         input logic [7:0] x, input logic [7:0] p);
    case (s)
      SRC_MAIN: src_mhz = m;
      SRC_XTAL: src_mhz = x;
      SRC_PIN:  src_mhz = p;
      default:  src_mhz = 8'h00;
    endcase
  endfunction : src_mhz

  assign dbl_src_mhz = src_mhz(dbl_cfg_q[`F_SRC], main_mhz, xtal_mhz, pin_clk_mhz);
  assign dbl_ok      = dbl_cfg_q[`F_EN] && dbl_src_mhz >= `DBL_MIN_MHZ
                       && dbl_src_mhz <= `DBL_MAX_MHZ;
  assign doubler_mhz = dbl_ok ? {dbl_src_mhz[6:0], 1'b0} : 8'h00;

  // ratio = p / q with p in 1..63 and q in 1..64: 63 x 64 = 4032 settings
  assign pll_ref_mhz  = src_mhz(pll_cfg_q[`F_SRC], main_mhz, xtal_mhz, pin_clk_mhz);
  assign pll_q        = {1'b0, pll_cfg_q[`F_PLL_QM1]} + 7'h01;
  assign pll_p        = pll_cfg_q[`F_PLL_P];
  assign pll_num      = 16'(pll_ref_mhz * pll_p);
  assign pll_lo       = 16'(`PLL_MIN_MHZ * pll_q);
  assign pll_hi       = 16'(`PLL_MAX_MHZ * pll_q);
  assign pll_range_ok = pll_p != 6'h00 && pll_num >= pll_lo && pll_num <= pll_hi;

  // ----------------------------------------------------------------
  // dividers: toggle flops so every derived clock is 50% duty
  // ----------------------------------------------------------------
  logic [7:0]  mdiv_q, mdiv_d;
  logic [13:0] c1k_q, c1k_d;
  logic [9:0]  c33_q, c33_d, c100_q, c100_d;
  logic        mclk_q, mclk_d, k1_q, k1_d, k33_q, k33_d, k100_q, k100_d;
  logic        tick_1k, hib;

  assign hib = power_mode == PM_HIB;

  always_comb
  begin
    mdiv_d = mdiv_q;
    mclk_d = mclk_q;
    c1k_d  = c1k_q;
    k1_d   = k1_q;
    c33_d  = c33_q;
    k33_d  = k33_q;
    c100_d = c100_q;
    k100_d = k100_q;
    if (!hib)
    begin
      mdiv_d = (mdiv_q >= osc_cfg_q[`F_OSC_DIV]) ? 8'h00 : mdiv_q + 8'h01;
      if (mdiv_q >= osc_cfg_q[`F_OSC_DIV])
        mclk_d = ~mclk_q;
      c1k_d  = (c1k_q == 14'(HALF_1K_CYC - 1)) ? 14'h0000 : c1k_q + 14'h0001;
      if (c1k_q == 14'(HALF_1K_CYC - 1))
        k1_d = ~k1_q;
      c33_d  = (c33_q == 10'(HALF_33K_CYC - 1)) ? 10'h000 : c33_q + 10'h001;
      if (c33_q == 10'(HALF_33K_CYC - 1))
        k33_d = ~k33_q;
      c100_d = (c100_q == 10'(HALF_100K_CYC - 1)) ? 10'h000 : c100_q + 10'h001;
      if (c100_q == 10'(HALF_100K_CYC - 1))
        k100_d = ~k100_q;
    end
  end
  assign tick_1k = !hib && c1k_q == 14'(HALF_1K_CYC - 1) && !k1_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mdiv_q <= 8'h00;
      mclk_q <= 1'b0;
      c1k_q  <= 14'h0000;
      k1_q   <= 1'b0;
      c33_q  <= 10'h000;
      k33_q  <= 1'b0;
      c100_q <= 10'h000;
      k100_q <= 1'b0;
    end
    else
    begin
      mdiv_q <= mdiv_d;
      mclk_q <= mclk_d;
      c1k_q  <= c1k_d;
      k1_q   <= k1_d;
      c33_q  <= c33_d;
      k33_q  <= k33_d;
      c100_q <= c100_d;
      k100_q <= k100_d;
    end
  end
  assign main_osc_div_clk   = mclk_q;
  assign one_khz_tick_clock = k1_q & osc_cfg_q[`F_OSC_1K];
  assign clk_33k            = k33_q & osc_cfg_q[`F_OSC_33K];
  assign clk_100k           = k100_q & osc_cfg_q[`F_OSC_100K];

  // ----------------------------------------------------------------
  // pll lock supervision and tick counter wheel
  // ----------------------------------------------------------------
  logic [12:0] lock_cnt_q, lock_cnt_d;
  logic        lock_q, lock_d;
  logic [12:0] wheel_q, wheel_d;
  logic        wirq_q, wirq_d;
  logic [12:0] tap_mask;
  logic        run_mode;

  assign run_mode   = power_mode == PM_ACTIVE || power_mode == PM_ALT;
  // low power modes rely on firmware having shut the pll; forcing it off is a backstop
  assign pll_enable = pll_cfg_q[`F_EN] && run_mode;
  assign tap_mask   = 13'((14'h0002 << wh_ctl_q[`F_WH_TAP]) - 14'h0001);

  always_comb
  begin
    lock_cnt_d = lock_cnt_q;
    lock_d     = lock_q;
    if (!pll_enable || !pll_range_ok)
    begin
      lock_cnt_d = 13'h0000;
      lock_d     = 1'b0;
    end
    else if (lock_cnt_q == 13'(LOCK_CYCLES - 1))
      lock_d = 1'b1;
    else
      lock_cnt_d = lock_cnt_q + 13'h0001;
    wheel_d = wheel_q;
    wirq_d  = 1'b0;
    if (wheel_clr)
      wheel_d = 13'h0000;
    else if (tick_1k && !debug_halt)
    begin
      wheel_d = wheel_q + 13'h0001;
      wirq_d  = ((wheel_d & tap_mask) == 13'h0000) && wh_ctl_q[`F_WH_TAP] <= `WHEEL_MAX_TAP;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      lock_cnt_q <= 13'h0000;
      lock_q     <= 1'b0;
      wheel_q    <= 13'h0000;
      wirq_q     <= 1'b0;
    end
    else
    begin
      lock_cnt_q <= lock_cnt_d;
      lock_q     <= lock_d;
      wheel_q    <= wheel_d;
      wirq_q     <= wirq_d;
    end
  end
  assign pll_lock    = lock_q;
  assign wheel_count = wheel_q;
  assign wheel_irq   = wirq_q & wh_ctl_q[`F_WH_IRQ];
  assign status      = {16'h0000, doubler_mhz, 3'h0, power_mode[4], dbl_ok, pll_range_ok, 1'b0, lock_q};

  // ----------------------------------------------------------------
  // power mode controller
  // ----------------------------------------------------------------
  pmode_t      mode_q, mode_d;
  logic [12:0] wcnt_q, wcnt_d;
  logic        rst_q, rst_d, sleep_wake, hib_wake, reset_hit;

  assign sleep_wake = wake_src.cmp | wake_src.port_irq | wake_src.i2c | wake_src.rtc
                      | wake_src.lsd | (wirq_q & wh_ctl_q[`F_WH_WAKE]);
  assign hib_wake   = wake_src.port_irq;

  always_comb
  begin
    mode_d    = mode_q;
    wcnt_d    = wcnt_q;
    reset_hit = 1'b0;
    case (mode_q)
      PM_ACTIVE, PM_ALT:
      begin
        reset_hit = |reset_src;
        if (mode_wr)
        begin
          case (wdata[`F_MODE])
            2'h0:    mode_d = PM_ACTIVE;
            2'h1:    mode_d = PM_ALT;
            2'h2:    mode_d = PM_SLEEP;
            default: mode_d = PM_HIB;
          endcase
        end
      end
      PM_SLEEP:
      begin
        reset_hit = |reset_src;
        if (sleep_wake)
        begin
          mode_d = PM_WAKE;
          wcnt_d = 13'(SLEEP_WAKE_CYC - 1);
        end
      end
      PM_HIB:
      begin
        reset_hit = reset_src.external_reset_pin;
        if (hib_wake)
        begin
          mode_d = PM_WAKE;
          wcnt_d = 13'(HIB_WAKE_CYC - 1);
        end
      end
      PM_WAKE:
      begin
        reset_hit = |reset_src;
        if (wcnt_q == 13'h0000)
          mode_d = PM_ACTIVE;
        else
          wcnt_d = wcnt_q - 13'h0001;
      end
      default: mode_d = PM_ACTIVE;
    endcase
    if (reset_hit)
      mode_d = PM_ACTIVE;
    rst_d = reset_hit;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mode_q <= PM_ACTIVE;
      wcnt_q <= 13'h0000;
      rst_q  <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      wcnt_q <= wcnt_d;
      rst_q  <= rst_d;
    end
  end

  assign power_mode      = mode_q;
  assign dev_reset_req   = rst_q;
  assign mode_code       = mode_q == PM_ALT ? 2'h1 : mode_q == PM_SLEEP ? 2'h2 : mode_q == PM_HIB ? 2'h3 : 2'h0;
  assign subsys_en       = mode_q == PM_ACTIVE ? tpl_q[`F_TPL_ACT] :
                           mode_q == PM_ALT ? tpl_q[`F_TPL_ALT] : 8'h00;
  assign sleep_timer_run = mode_q != PM_HIB;
  assign clocks_run      = mode_q != PM_HIB;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_lock_after_time: assert property (pll_enable && pll_range_ok && !lock_q && lock_cnt_q == 13'h0000
    && !$past(lock_q) |-> !lock_q [*8]) else $error("pll locked too early");
  a_lock_needs_en: assert property (lock_q |-> $past(pll_enable && pll_range_ok))
    else $error("lock without enabled pll");
  a_pll_off_low: assert property (!run_mode |=> !lock_q)
    else $error("pll lock held in low power");
  a_wheel_clear: assert property (wheel_clr |=> wheel_q == 13'h0000)
    else $error("wheel clear lost");
  a_wheel_hold_hib: assert property (hib && !wheel_clr |=> $stable(wheel_q))
    else $error("wheel moved in hibernate");
  a_wheel_step: assert property (tick_1k && !debug_halt && !wheel_clr
    |=> wheel_q == $past(wheel_q) + 13'h0001) else $error("wheel did not step");
  a_hib_pin_wake: assert property (mode_q == PM_HIB && !hib_wake && !reset_src.external_reset_pin
    |=> mode_q == PM_HIB) else $error("hibernate left without pin event");
  a_sleep_wake_time: assert property (mode_q == PM_SLEEP && sleep_wake && !reset_hit |=> mode_q == PM_WAKE
    ##[1:SLEEP_WAKE_CYC] mode_q == PM_ACTIVE) else $error("sleep wake too slow");
  a_sleep_en_off: assert property (mode_q == PM_SLEEP |-> subsys_en == 8'h00)
    else $error("subsystem on in sleep");
  a_tpl_active: assert property (mode_q == PM_ACTIVE |-> subsys_en == tpl_q[`F_TPL_ACT])
    else $error("template not applied");
  a_dbl_range: assert property (doubler_mhz != 8'h00 |-> doubler_mhz >= 8'h0c && doubler_mhz <= 8'h30)
    else $error("doubler out of range");

  c_pll_lock:   cover property (pll_enable ##1 lock_q);
  c_sleep_wake: cover property (mode_q == PM_SLEEP ##1 mode_q == PM_WAKE);
  c_hib_reset:  cover property (mode_q == PM_HIB && reset_src.external_reset_pin ##1 dev_reset_req);
  c_wheel_irq:  cover property (wheel_irq);

endmodule : clock_and_power_mode_control

/* File: test/tb.sv */
// Purpose: self-checking bench for the clock and power mode controller
// Assumes: short lock, hibernate-wake and 1 kHz counts set at the instance
// Notes:   table rows cover oscillator and doubler choices, hand tests the rest
`include "clk_pwr_params.svh"
`timescale 1ns/10ps
module tb
  import clk_pwr_pkg::*;
;
  logic        clk, sys_rst, wr_stb, rd_stb, debug_halt;
  logic [7:0]  addr, xtal_mhz, pin_clk_mhz, doubler_mhz, subsys_en;
  logic [31:0] wdata, rdata, v;
  wake_src_t   wake_src;
  reset_src_t  reset_src;
  logic [2:0]  main_osc_sel;
  logic        main_osc_div_clk, one_khz_tick_clock, clk_33k, clk_100k, pll_enable, pll_lock;
  logic [12:0] wheel_count, w;
  logic        wheel_irq, sleep_timer_run, clocks_run, dev_reset_req;
  pmode_t      power_mode;
  int          n_fail, num_checks, hi_a, hi_b;

  typedef struct packed {
    logic [31:0] osc;
    logic [31:0] dbl;
    logic [7:0]  xt;
    logic [7:0]  pn;
    logic [7:0]  exp;
  } row_t;
  row_t rows [12] = '{
    '{32'h0, 32'h1, 8'h00, 8'h00, 8'h00}, '{32'h1, 32'h1, 8'h00, 8'h00, 8'h0c},
    '{32'h2, 32'h1, 8'h00, 8'h00, 8'h18}, '{32'h3, 32'h1, 8'h00, 8'h00, 8'h30},
    '{32'h4, 32'h1, 8'h00, 8'h00, 8'h00}, '{32'h5, 32'h1, 8'h00, 8'h00, 8'h00},
    '{32'h1, 32'h3, 8'h06, 8'h00, 8'h0c}, '{32'h1, 32'h3, 8'h18, 8'h00, 8'h30},
    '{32'h1, 32'h3, 8'h19, 8'h00, 8'h00}, '{32'h1, 32'h3, 8'h05, 8'h00, 8'h00},
    '{32'h1, 32'h5, 8'h00, 8'h0a, 8'h14}, '{32'h1, 32'h2, 8'h18, 8'h00, 8'h00}};

  clock_and_power_mode_control #(.LOCK_CYCLES(20), .HIB_WAKE_CYC(30), .HALF_1K_CYC(8)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .xtal_mhz(xtal_mhz), .pin_clk_mhz(pin_clk_mhz), .debug_halt(debug_halt),
    .wake_src(wake_src), .reset_src(reset_src), .main_osc_sel(main_osc_sel),
    .main_osc_div_clk(main_osc_div_clk), .one_khz_tick_clock(one_khz_tick_clock), .clk_33k(clk_33k),
    .clk_100k(clk_100k), .doubler_mhz(doubler_mhz), .pll_enable(pll_enable), .pll_lock(pll_lock),
    .wheel_count(wheel_count), .wheel_irq(wheel_irq), .power_mode(power_mode), .subsys_en(subsys_en),
    .sleep_timer_run(sleep_timer_run), .clocks_run(clocks_run), .dev_reset_req(dev_reset_req));

  // ----------------------------------------
  // clock, watchdog, helpers
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end

  task automatic end_sim();
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic chk_mode(input pmode_t e);
    num_checks++;
    if (power_mode !== e)
    begin
      n_fail++;
      $display("[FAIL] t=%0t mode=%h exp=%h", $time, power_mode, e);
    end
  endtask : chk_mode

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a; rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask : rd

  // one-cycle event on the wake and reset inputs
  task automatic pulse(input wake_src_t ws, input reset_src_t rs);
    @(posedge clk);
    wake_src <= ws; reset_src <= rs;
    @(posedge clk);
    wake_src <= '0; reset_src <= '0;
    #1;
  endtask : pulse

  // bounded wait, a miss counts as a mismatch
  task automatic wait_mode(input pmode_t m, input int lim);
    for (int i = 0; i < lim && power_mode !== m; i++) @(posedge clk) #1;
    chk_mode(m);
  endtask : wait_mode

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    sys_rst = 1'b1; wr_stb = 1'b0; rd_stb = 1'b0; addr = 8'h00; wdata = 32'h0; debug_halt = 1'b0;
    xtal_mhz = 8'h00; pin_clk_mhz = 8'h00; wake_src = '0; reset_src = '0;
    n_fail = 0; num_checks = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk_mode(PM_ACTIVE);
    chk(subsys_en, 32'hff);
    chk(pll_lock, 32'h0);
    rd(`ADDR_OSC_CFG); chk(v, 32'h1);
    rd(8'h20); chk(v, 32'h0);
    foreach (rows[i])
    begin
      @(posedge clk);
      xtal_mhz <= rows[i].xt; pin_clk_mhz <= rows[i].pn;
      wr(`ADDR_OSC_CFG, rows[i].osc);
      wr(`ADDR_DBL_CFG, rows[i].dbl);
      chk(main_osc_sel, rows[i].osc);
      chk(doubler_mhz, rows[i].exp);
    end
    rd(`ADDR_STATUS); chk(v[15:8], 32'h0);
    // divided clocks: a window of whole periods holds exactly half highs
    wr(`ADDR_OSC_CFG, 32'h0000_0339);
    hi_a = 0; hi_b = 0;
    repeat (48)
    begin
      @(posedge clk) #1;
      hi_a += main_osc_div_clk;
      hi_b += one_khz_tick_clock;
    end
    chk(hi_a, 32'd24);
    chk(hi_b, 32'd24);
    // slow clocks over whole periods: halves of 378 and 125 cycles
    hi_a = 0;
    hi_b = 0;
    for (int i = 0; i < 1512; i++)
    begin
      @(posedge clk) #1;
      hi_a += clk_33k;
      if (i < 1500)
        hi_b += clk_100k;
    end
    chk(hi_a, 32'd756);
    chk(hi_b, 32'd750);
    // pll: 6 MHz main times 8 gives 48 MHz
    wr(`ADDR_PLL_CFG, 32'h0008_0001);
    chk(pll_enable, 32'h1);
    repeat (10) @(posedge clk) #1;
    chk(pll_lock, 32'h0);
    for (int i = 0; i < 30 && pll_lock !== 1'b1; i++) @(posedge clk) #1;
    chk(pll_lock, 32'h1);
    rd(`ADDR_STATUS); chk(v & 32'h5, 32'h5);
    wr(`ADDR_PLL_CFG, 32'h0002_0001);
    repeat (2) @(posedge clk) #1;
    chk(pll_lock, 32'h0);
    wr(`ADDR_PLL_CFG, 32'h0008_0001);
    // tick wheel
    wr(`ADDR_WHEEL_CTL, 32'h1);
    w = wheel_count;
    repeat (48) @(posedge clk) #1;
    chk(wheel_count - w, 32'd3);
    debug_halt <= 1'b1;
    @(posedge clk) #1 w = wheel_count;
    repeat (48) @(posedge clk) #1;
    chk(wheel_count, w);
    debug_halt <= 1'b0;
    wr(`ADDR_WHEEL_CTL, 32'h21);
    chk(wheel_count, 32'h0);
    rd(`ADDR_WHEEL_CTL); chk(v[0], 32'h0);
    hi_a = 0;
    repeat (64)
    begin
      @(posedge clk) #1;
      hi_a += wheel_irq;
    end
    chk(hi_a, 32'd2);
    // power modes
    wr(`ADDR_TEMPLATE, 32'h5a3c);
    chk(subsys_en, 32'h3c);
    wr(`ADDR_MODE, 32'h1);
    chk_mode(PM_ALT);
    chk(subsys_en, 32'h5a);
    rd(`ADDR_MODE); chk(v[1:0], 32'h1);
    wr(`ADDR_MODE, 32'h2);
    chk_mode(PM_SLEEP);
    chk(subsys_en, 32'h0);
    chk(pll_enable, 32'h0);
    chk(sleep_timer_run, 32'h1);
    wr(`ADDR_MODE, 32'h3);
    chk_mode(PM_SLEEP);
    pulse(5'b00100, '0);
    chk_mode(PM_WAKE);
    repeat (600) @(posedge clk) #1;
    chk_mode(PM_WAKE);
    wait_mode(PM_ACTIVE, 60);
    wr(`ADDR_MODE, 32'h3);
    chk_mode(PM_HIB);
    chk(clocks_run, 32'h0);
    w = wheel_count;
    pulse(5'b10001, 3'b010);
    chk_mode(PM_HIB);
    repeat (40) @(posedge clk) #1;
    chk(wheel_count, w);
    pulse(5'b01000, '0);
    chk_mode(PM_WAKE);
    repeat (25) @(posedge clk) #1;
    chk_mode(PM_WAKE);
    wait_mode(PM_ACTIVE, 10);
    wr(`ADDR_MODE, 32'h2);
    pulse('0, 3'b001);
    chk_mode(PM_ACTIVE);
    chk(dev_reset_req, 32'h1);
    // wheel event wakes the part from sleep
    wr(`ADDR_WHEEL_CTL, 32'h60);
    wr(`ADDR_MODE, 32'h2);
    wait_mode(PM_WAKE, 40);
    wait_mode(PM_ACTIVE, 700);
    // hibernate still answers the external reset pin
    wr(`ADDR_MODE, 32'h3);
    pulse('0, 3'b100);
    chk_mode(PM_ACTIVE);
    chk(dev_reset_req, 32'h1);
    // mid-run reset taken from alternate active
    wr(`ADDR_MODE, 32'h1);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk_mode(PM_ACTIVE);
    chk(subsys_en, 32'hff);
    chk(wheel_count, 32'h0);
    rd(`ADDR_OSC_CFG); chk(v, 32'h1);
    end_sim();
  end
endmodule : tb
